// >>> bench/pad_board_model.sv
// Board-side model of the shared pads: pulls, keeper and floating levels
`timescale 1ns/1ns
module pad_board_model #(
  parameter int NPADS = 8,  // Core pads
  parameter int NBATT = 2   // Battery pads
) (
  input  wire logic             ref_clk,
  input  wire logic [NPADS-1:0] padOut,
  input  wire logic [NPADS-1:0] padOe,
  input  wire logic [NPADS-1:0] padPullUp,
  input  wire logic [NPADS-1:0] padPullDown,
  input  wire logic [NPADS-1:0] padKeeper,
  input  wire logic [NBATT-1:0] battPadOut,
  input  wire logic [NBATT-1:0] battPadOe,
  output logic      [NPADS-1:0] padIn,
  output logic      [NBATT-1:0] battPadIn
);
  logic [NPADS-1:0] kept = '0;    // Level held by the bus keeper
  logic             flip = 1'b0;  // Floating lines wander every cycle

  // Keeper follows the wire; floating level flips so stale data never passes
  always @(posedge ref_clk) begin
    flip <= ~flip;
    kept <= padIn;
  end

  // Resolve each wire from driver, pulls and keeper
  always_comb begin
    for (int i = 0; i < NPADS; i++) begin
      if (padOe[i]) padIn[i] = padOut[i];
      else if (padPullUp[i]) padIn[i] = 1'b1;
      else if (padPullDown[i]) padIn[i] = 1'b0;
      else if (padKeeper[i]) padIn[i] = kept[i];
      else padIn[i] = flip ^ i[0];
    end
    for (int j = 0; j < NBATT; j++) begin
      battPadIn[j] = battPadOe[j] ? battPadOut[j] : ~flip;
    end
  end
endmodule

// >>> bench/test_gpio_pad_owner_config.sv
// Self-checking bench for the shared pad owner and configuration block
`timescale 1ns/1ns
module test_gpio_pad_owner_config;
  localparam int NP = pad_owner_pkg::NUM_PADS;              // Core pads
  localparam int NB = pad_owner_pkg::NUM_BATT;              // Battery pads
  localparam logic [7:0] CFG0 = pad_owner_pkg::PAD_CFG_BASE;  // First core pad word
  localparam logic [7:0] BAT0 = pad_owner_pkg::BATT_CFG_BASE; // First battery word
  localparam logic [31:0] CRST = 32'(pad_owner_pkg::PAD_CFG_RST); // Core pad word after reset

  logic            ref_clk, srst, hsel, hwrite, hready, hreadyout, hresp, coreOk;
  logic [31:0]     haddr, hwdata, hrdata, rd, w;
  logic [1:0]      htrans;
  logic [2:0]      hsize, powerState;
  logic [NP-1:0]   secOut, secOe, hpOut, hpOe, lpOut, lpOe, secIn, hpIn, lpIn, exp;
  logic [NP-1:0]   padIn, padOut, padOe, padSlewFast, padSchmitt;
  logic [NP-1:0]   padPullUp, padPullDown, padKeeper;
  logic [2*NP-1:0] padDrive;
  logic [NB-1:0]   battOwnOut, battOwnIn, battPadIn, battPadOut, battPadOe, battVoltSel;
  logic            up;          // Pad expected to be live
  int              nFail;       // Mismatches seen
  int              checkCount;  // Comparisons made

  assign hready = hreadyout;  // Single slave: its ready is the bus ready

  // ************************************
  // Clock, design and board
  // ************************************
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  gpio_pad_owner_config #(.NPADS(NP), .NBATT(NB)) dut (
    .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .powerState(powerState),
    .core_power_valid(coreOk), .secOut(secOut), .secOe(secOe), .hpOut(hpOut),
    .hpOe(hpOe), .lpOut(lpOut), .lpOe(lpOe), .secIn(secIn), .hpIn(hpIn), .lpIn(lpIn),
    .padIn(padIn), .padOut(padOut), .padOe(padOe), .padDrive(padDrive),
    .padSlewFast(padSlewFast), .padSchmitt(padSchmitt), .padPullUp(padPullUp),
    .padPullDown(padPullDown), .padKeeper(padKeeper), .battOwnOut(battOwnOut),
    .battOwnIn(battOwnIn), .battPadIn(battPadIn), .battPadOut(battPadOut),
    .battPadOe(battPadOe), .battVoltSel(battVoltSel));

  pad_board_model #(.NPADS(NP), .NBATT(NB)) board (
    .ref_clk(ref_clk), .padOut(padOut), .padOe(padOe), .padPullUp(padPullUp),
    .padPullDown(padPullDown), .padKeeper(padKeeper), .battPadOut(battPadOut),
    .battPadOe(battPadOe), .padIn(padIn), .battPadIn(battPadIn));

  // ************************************
  // Shared tasks
  // ************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    checkCount++;
    if (seen !== want) begin
      nFail++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask

  // Bounded wait so a stuck ready cannot hang the run
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hready !== 1'b1 && n < 16) begin
      n++;
      @(posedge ref_clk);
    end
    if (n >= 16) check("hready", hready, 32'h1);
  endtask

  // One single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    hsize  <= pad_owner_pkg::HSIZE_WORD;
    htrans <= pad_owner_pkg::HTRANS_NONSEQ;
    wait_ready();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wr ? wd : 32'h0;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] want);
    bus(1'b0, a, 32'h0);
    check(what, rd, want);
  endtask

  // Pad outputs update on the first edge, owner inputs one edge later
  task automatic settle();
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog: the tests need about two hundred cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    nFail++;
    report_and_stop();
  end

  // ************************************
  // Tests
  // ************************************
  initial begin
    nFail = 0;
    checkCount = 0;
    srst = 1'b1;
    {hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
    {secOut, secOe, hpOut, hpOe, lpOut, lpOe, battOwnOut} = '0;
    powerState = pad_owner_pkg::PS_FULL;
    coreOk = 1'b1;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    // Defaults after reset
    for (int i = 0; i < NP; i++) rdchk("pad cfg", CFG0 + 8'(4 * i), CRST);
    rdchk("batt cfg", BAT0, 32'h0);
    check("reset oe", padOe, 32'h0);
    check("reset pulls", {padPullUp, padPullDown, padKeeper}, 32'h0);
    $display("test reset defaults done");
    // Owner select against every power state; code 3 leaves pads unowned
    {secOe, hpOe, lpOe} <= '1;
    secOut <= 8'hA5;
    hpOut  <= 8'h5A;
    lpOut  <= 8'h3C;
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < NP; i++) wr(CFG0 + 8'(4 * i), 32'(k));
      rdchk("owner word", CFG0 + 8'h1C, 32'(k));
      exp = (k == 0) ? 8'hA5 : (k == 1) ? 8'h5A : 8'h3C;
      for (int s = 4; s >= 0; s--) begin
        powerState <= 3'(s);
        settle();
        up = k < 3 && (s >= 3 || (k == 2 && s == 2));
        check("padOe", padOe, up ? 32'hFF : 32'h0);
        if (up) check("padOut", padOut, exp);
        check("secIn", secIn, (up && k == 0) ? exp : 8'h0);
        check("hpIn", hpIn, (up && k == 1) ? exp : 8'h0);
        check("lpIn", lpIn, (up && k == 2) ? exp : 8'h0);
      end
      powerState <= pad_owner_pkg::PS_FULL;
      coreOk <= 1'b0;
      settle();
      check("no power oe", padOe, 32'h0);
      coreOk <= 1'b1;
    end
    $display("test owners and power states done");
    // Drive, slew, hysteresis and pull on pad 3, owner not driving
    lpOe <= '0;
    for (int c = 0; c < 4; c++) begin
      w = 32'h2 | (32'(c) << pad_owner_pkg::DRIVE_LSB) | (32'(c & 1) << pad_owner_pkg::SLEW_BIT)
        | (32'(c >> 1) << pad_owner_pkg::HYST_BIT) | (32'(c) << pad_owner_pkg::PULL_LSB);
      wr(CFG0 + 8'h0C, w);
      settle();
      check("drive", padDrive[7:6], 32'(c));
      check("slew", padSlewFast[3], 32'(c & 1));
      check("schmitt", padSchmitt[3], 32'(c >> 1));
      check("pulls", {padPullUp[3], padPullDown[3], padKeeper[3]}, {c == 1, c == 2, c == 3});
      rdchk("cfg word", CFG0 + 8'h0C, w);
      if (c == 1 || c == 2) check("pulled level", lpIn[3], 32'(c == 1));
    end
    $display("test pad settings done");
    // Open drain on pad 5: enable carries the data
    wr(CFG0 + 8'h14, 32'h22);
    lpOe  <= 8'h20;
    lpOut <= 8'h00;
    settle();
    check("od low oe", padOe[5], 32'h1);
    check("od low out", padOut[5], 32'h0);
    lpOut <= 8'h20;
    settle();
    check("od float", padOe[5], 32'h0);
    check("od input", lpIn[5], 32'h1);
    $display("test open drain done");
    // Reset in mid-run tri-states and restores defaults
    wr(CFG0, 32'h0);
    settle();
    check("live before reset", padOe[0], 32'h1);
    srst <= 1'b1;
    settle();
    check("oe in reset", padOe, 32'h0);
    srst <= 1'b0;
    @(posedge ref_clk);
    rdchk("cfg after reset", CFG0, CRST);
    check("oe after reset", padOe, 32'h0);
    $display("test mid-run reset done");
    // Battery pads: two settings only, live in sleep without core power
    wr(CFG0, 32'h0);
    wr(BAT0, 32'hFFFFFFFF);
    rdchk("batt cfg", BAT0, 32'h3);
    battOwnOut <= 2'h1;
    powerState <= pad_owner_pkg::PS_SLEEP;
    coreOk <= 1'b0;
    settle();
    check("batt oe", battPadOe, 32'h1);
    check("batt out", battPadOut[0], 32'h1);
    check("batt vsel", battVoltSel, 32'h1);
    check("core oe off", padOe, 32'h0);
    powerState <= pad_owner_pkg::PS_DEEP;
    settle();
    check("batt deep", battPadOe, 32'h1);
    check("batt in", battOwnIn[0], 32'h1);
    $display("test battery pads done");
    // Unmapped place ignores writes and reads zero
    wr(8'hC0, 32'h12345678);
    rdchk("unmapped", 8'hC0, 32'h0);
    $display("test unmapped done");
    report_and_stop();
  end
endmodule

// >>> shared/pad_owner_pkg.sv
// Package of register offsets, field layouts and encodings for the pad owner block
package pad_owner_pkg;

  // ********************************************
  // Geometry
  // ********************************************
  localparam int NUM_PADS   = 8;   // Shared core-domain pads
  localparam int NUM_BATT   = 2;   // Always-on battery-domain pads

  // ********************************************
  // Register offsets (byte addresses)
  // ********************************************
  localparam logic [7:0] PAD_CFG_BASE  = 8'h00; // One word per core pad
  localparam logic [7:0] BATT_CFG_BASE = 8'h40; // One word per battery pad
  localparam logic [7:0] PWR_STAT_OFF  = 8'h80; // Read-only power and gating status
  localparam logic [7:0] PAD_IN_OFF    = 8'h84; // Read-only sensed pad levels

  // ********************************************
  // Core pad config fields
  // ********************************************
  localparam int OWNER_LSB = 0;   // 2 bits
  localparam int DRIVE_LSB = 2;   // 2 bits
  localparam int SLEW_BIT  = 4;
  localparam int OD_BIT    = 5;
  localparam int HYST_BIT  = 6;
  localparam int PULL_LSB  = 7;   // 2 bits
  localparam int CFG_W     = 9;

  // Battery pad config fields
  localparam int BDIR_BIT  = 0;
  localparam int BVSEL_BIT = 1;
  localparam int BCFG_W    = 2;

  // ********************************************
  // Reset values: no owner drive, plain input
  // ********************************************
  localparam logic [CFG_W-1:0]  PAD_CFG_RST  = 9'h003; // Owner code 3: nobody drives the pad
  localparam logic [BCFG_W-1:0] BATT_CFG_RST = 2'h0;

  // ********************************************
  // Encodings
  // ********************************************
  typedef enum logic [1:0] {
    OWN_SECURE = 2'h0,   // secure_zone_cpu
    OWN_HIPERF = 2'h1,   // high_perf_app_cpu
    OWN_LOWPWR = 2'h2    // low_power_app_cpu
  } owner_t;

  typedef enum logic [1:0] {
    PULL_NONE = 2'h0,
    PULL_UP   = 2'h1,
    PULL_DOWN = 2'h2,
    PULL_KEEP = 2'h3
  } pull_t;

  typedef enum logic [2:0] {
    PS_FULL   = 3'h4,    // full_active_state
    PS_REDUCE = 3'h3,    // reduced_active_state
    PS_LOW    = 3'h2,
    PS_SLEEP  = 3'h1,
    PS_DEEP   = 3'h0
  } pstate_t;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

endpackage

// >>> verilog/gpio_pad_owner_config.sv
// Top of the shared pad owner and configuration block with its AHB-Lite slave
// What this block does
// - Each pad served by at most one owner; code 3 leaves it unowned
// - Software owner field picks each pad's owner
// - Secure and fast cpu pads: active states only
// - Low power cpu pads work except in sleep and deep sleep
// - Battery pads work in every state
// - Four drive strength codes per core pad
// - Slow or fast slew per core pad
// - Open drain: input fixed, enable is data
// - Hysteresis on or off per core pad
// - Pull up, down, keeper or none
// - Power invalid tri-states all core pads
// - Reset or deep sleep tri-states core pads
// - Battery pads: direction and voltage only
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module gpio_pad_owner_config #(
  parameter int NPADS = pad_owner_pkg::NUM_PADS,  // Core pads
  parameter int NBATT = pad_owner_pkg::NUM_BATT   // Battery pads
) (
  input  wire logic               ref_clk,
  input  wire logic               srst,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic [31:0]             hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // System state
  input  wire logic [2:0]         powerState,
  input  wire logic               core_power_valid,
  // Owner sides, one bit per pad each
  input  wire logic [NPADS-1:0]   secOut,
  input  wire logic [NPADS-1:0]   secOe,
  input  wire logic [NPADS-1:0]   hpOut,
  input  wire logic [NPADS-1:0]   hpOe,
  input  wire logic [NPADS-1:0]   lpOut,
  input  wire logic [NPADS-1:0]   lpOe,
  output logic [NPADS-1:0]        secIn,
  output logic [NPADS-1:0]        hpIn,
  output logic [NPADS-1:0]        lpIn,
  // Core pads
  input  wire logic [NPADS-1:0]   padIn,
  output logic [NPADS-1:0]        padOut,
  output logic [NPADS-1:0]        padOe,
  output logic [2*NPADS-1:0]      padDrive,
  output logic [NPADS-1:0]        padSlewFast,
  output logic [NPADS-1:0]        padSchmitt,
  output logic [NPADS-1:0]        padPullUp,
  output logic [NPADS-1:0]        padPullDown,
  output logic [NPADS-1:0]        padKeeper,
  // Battery pads, driven by the low power cpu
  input  wire logic [NBATT-1:0]   battOwnOut,
  output logic [NBATT-1:0]        battOwnIn,
  input  wire logic [NBATT-1:0]   battPadIn,
  output logic [NBATT-1:0]        battPadOut,
  output logic [NBATT-1:0]        battPadOe,
  output logic [NBATT-1:0]        battVoltSel
);

  // ********************************************
  // Configuration storage
  // ********************************************
  logic [pad_owner_pkg::CFG_W-1:0]  padCfg  [NPADS];   // Core pad config words
  logic [pad_owner_pkg::BCFG_W-1:0] battCfg [NBATT];   // Battery pad config words

  // ********************************************
  // Power state decode
  // ********************************************
  logic hiPerfOk;   // Secure / fast owners usable
  logic lowPwrOk;   // Low power owner usable
  logic forceOff;   // Global tri-state request

  // Fast owners live only in the two active states
  assign hiPerfOk = (powerState == pad_owner_pkg::PS_FULL) ||
                    (powerState == pad_owner_pkg::PS_REDUCE);
  // Low power owner drops out in both sleep states
  assign lowPwrOk = (powerState != pad_owner_pkg::PS_SLEEP) &&
                    (powerState != pad_owner_pkg::PS_DEEP);
  // Invalid core power and deep sleep override every owner's enable
  assign forceOff = !core_power_valid ||
                    (powerState == pad_owner_pkg::PS_DEEP);

  // ********************************************
  // AHB-Lite slave: zero wait states
  // ********************************************
  logic        wrPend;    // Write data phase pending
  logic [7:0]  wrAddr;    // Latched write address
  logic        acc;       // Valid address phase accepted
  logic [31:0] next_rdata;

  assign acc = hsel && hready && (htrans == pad_owner_pkg::HTRANS_NONSEQ);

  // Capture address phase
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
    end else begin
      wrPend <= acc && hwrite;
      if (acc) begin
        wrAddr <= haddr[7:0];
      end
    end
  end

  // Always ready, always OKAY; unmapped reads give zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Config writes; battery words carry only two bits
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < NPADS; i++) begin
        padCfg[i] <= pad_owner_pkg::PAD_CFG_RST;
      end
      for (int j = 0; j < NBATT; j++) begin
        battCfg[j] <= pad_owner_pkg::BATT_CFG_RST;
      end
    end else if (wrPend) begin
      for (int i = 0; i < NPADS; i++) begin
        if (wrAddr == pad_owner_pkg::PAD_CFG_BASE + 8'(4 * i)) begin
          padCfg[i] <= hwdata[pad_owner_pkg::CFG_W-1:0];
        end
      end
      for (int j = 0; j < NBATT; j++) begin
        if (wrAddr == pad_owner_pkg::BATT_CFG_BASE + 8'(4 * j)) begin
          battCfg[j] <= hwdata[pad_owner_pkg::BCFG_W-1:0];
        end
      end
    end
  end

  // Read mux, decoded from the address phase itself
  always_comb begin
    next_rdata = 32'h0000_0000;
    for (int i = 0; i < NPADS; i++) begin
      if (haddr[7:0] == pad_owner_pkg::PAD_CFG_BASE + 8'(4 * i)) begin
        next_rdata = 32'(padCfg[i]);
      end
    end
    for (int j = 0; j < NBATT; j++) begin
      if (haddr[7:0] == pad_owner_pkg::BATT_CFG_BASE + 8'(4 * j)) begin
        next_rdata = 32'(battCfg[j]);
      end
    end
    if (haddr[7:0] == pad_owner_pkg::PWR_STAT_OFF) begin
      next_rdata = {26'h0, forceOff, lowPwrOk, hiPerfOk, powerState};
    end
    if (haddr[7:0] == pad_owner_pkg::PAD_IN_OFF) begin
      next_rdata = 32'(padIn);
    end
  end

  // Read data flop: loaded at the address phase edge, stands through the data phase
  // Trade-off: data reflect state at the address phase, not at the data phase end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hrdata <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      hrdata <= next_rdata;
    end else begin
      hrdata <= 32'h0000_0000;
    end
  end

  // ********************************************
  // Core pads
  // ********************************************
  genvar g;
  generate
    for (g = 0; g < NPADS; g++) begin : genPad
      logic [2:0] ownIn;  // Sensed level routed per owner
      pad_cell_ctrl u_pad (
        .ref_clk     (ref_clk),
        .srst        (srst),
        .cfg         (padCfg[g]),
        .ownOut      ({lpOut[g], hpOut[g], secOut[g]}),
        .ownOe       ({lpOe[g], hpOe[g], secOe[g]}),
        .padIn       (padIn[g]),
        .hiPerfOk    (hiPerfOk),
        .lowPwrOk    (lowPwrOk),
        .forceOff    (forceOff),
        .padOut      (padOut[g]),
        .padOe       (padOe[g]),
        .padDrive    (padDrive[2*g +: 2]),
        .padSlewFast (padSlewFast[g]),
        .padSchmitt  (padSchmitt[g]),
        .padPullUp   (padPullUp[g]),
        .padPullDown (padPullDown[g]),
        .padKeeper   (padKeeper[g]),
        .ownIn       (ownIn)
      );
      assign secIn[g] = ownIn[0];
      assign hpIn[g]  = ownIn[1];
      assign lpIn[g]  = ownIn[2];
    end
  endgenerate

  // ********************************************
  // Battery pads: never gated by power state
  // ********************************************
  // Direction and supply select only, no other settings exist
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      battPadOut  <= '0;
      battPadOe   <= '0;
      battVoltSel <= '0;
      battOwnIn   <= '0;
    end else begin
      for (int j = 0; j < NBATT; j++) begin
        battPadOut[j]  <= battOwnOut[j];
        battPadOe[j]   <= battCfg[j][pad_owner_pkg::BDIR_BIT];
        battVoltSel[j] <= battCfg[j][pad_owner_pkg::BVSEL_BIT];
        battOwnIn[j]   <= battPadIn[j];
      end
    end
  end

  // ********************************************
  // Checks
  // ********************************************
  battFree_a: assert property (@(posedge ref_clk) disable iff (srst)
    ##1 battPadOe[0] == $past(battCfg[0][pad_owner_pkg::BDIR_BIT]))
    else $error("battery pad direction not following config");
  resetTri_a: assert property (@(posedge ref_clk)
    srst |=> (padOe == '0) && (battPadOe == '0))
    else $error("pad enabled after reset");
  busOkay_a: assert property (@(posedge ref_clk) disable iff (srst)
    ##1 hreadyout && !hresp)
    else $error("slave not ready or error");
  deepSleepTri_a: assert property (@(posedge ref_clk) disable iff (srst)
    (powerState == pad_owner_pkg::PS_DEEP) [*2] |-> (padOe == '0))
    else $error("core pad driven in deep sleep");

endmodule

// >>> verilog/pad_cell_ctrl.sv
// One core-domain pad: owner select, availability gating and pad control outputs
`timescale 1ns/1ns
module pad_cell_ctrl (
  input  wire logic                               ref_clk,
  input  wire logic                               srst,
  input  wire logic [pad_owner_pkg::CFG_W-1:0]    cfg,
  input  wire logic [2:0]                         ownOut,
  input  wire logic [2:0]                         ownOe,
  input  wire logic                               padIn,
  input  wire logic                               hiPerfOk,
  input  wire logic                               lowPwrOk,
  input  wire logic                               forceOff,
  output logic                                    padOut,
  output logic                                    padOe,
  output logic [1:0]                              padDrive,
  output logic                                    padSlewFast,
  output logic                                    padSchmitt,
  output logic                                    padPullUp,
  output logic                                    padPullDown,
  output logic                                    padKeeper,
  output logic [2:0]                              ownIn
);

  // ********************************************
  // Owner decode
  // ********************************************
  logic [1:0] owner;          // Selected owner code
  logic       avail;          // Owner usable in current power state
  logic       selOut;         // Owner data
  logic       selOe;          // Owner enable
  logic       next_out;
  logic       next_oe;

  assign owner = cfg[pad_owner_pkg::OWNER_LSB +: 2];

  // Pick owner signals and its power-state availability
  always_comb begin
    selOut = 1'b0;
    selOe  = 1'b0;
    avail  = 1'b0;
    case (owner)
      pad_owner_pkg::OWN_SECURE: begin
        selOut = ownOut[0];
        selOe  = ownOe[0];
        avail  = hiPerfOk;
      end
      pad_owner_pkg::OWN_HIPERF: begin
        selOut = ownOut[1];
        selOe  = ownOe[1];
        avail  = hiPerfOk;
      end
      pad_owner_pkg::OWN_LOWPWR: begin
        selOut = ownOut[2];
        selOe  = ownOe[2];
        avail  = lowPwrOk;
      end
      default: begin
        // Unused code: nobody owns the pad
        avail  = 1'b0;
      end
    endcase
  end

  // Open drain: only ever pull low, enable carries the data
  always_comb begin
    if (cfg[pad_owner_pkg::OD_BIT]) begin
      next_out = 1'b0;
      next_oe  = selOe & ~selOut;
    end else begin
      next_out = selOut;
      next_oe  = selOe;
    end
    if (!avail || forceOff) begin
      next_oe  = 1'b0;
    end
  end

  // ********************************************
  // Registered pad outputs
  // ********************************************
  // Pad drive and enable
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      padOut <= 1'b0;
      padOe  <= 1'b0;
    end else begin
      padOut <= next_out;
      padOe  <= next_oe;
    end
  end

  // Electrical settings straight from the config word
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      padDrive    <= 2'h0;
      padSlewFast <= 1'b0;
      padSchmitt  <= 1'b0;
      padPullUp   <= 1'b0;
      padPullDown <= 1'b0;
      padKeeper   <= 1'b0;
    end else begin
      padDrive    <= cfg[pad_owner_pkg::DRIVE_LSB +: 2];
      padSlewFast <= cfg[pad_owner_pkg::SLEW_BIT];
      padSchmitt  <= cfg[pad_owner_pkg::HYST_BIT];
      padPullUp   <= cfg[pad_owner_pkg::PULL_LSB +: 2] == pad_owner_pkg::PULL_UP;
      padPullDown <= cfg[pad_owner_pkg::PULL_LSB +: 2] == pad_owner_pkg::PULL_DOWN;
      padKeeper   <= cfg[pad_owner_pkg::PULL_LSB +: 2] == pad_owner_pkg::PULL_KEEP;
    end
  end

  // Sensed level goes to the owner only; open drain reads fixed high
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ownIn <= 3'h0;
    end else begin
      ownIn <= 3'h0;
      if (avail) begin
        case (owner)
          pad_owner_pkg::OWN_SECURE: ownIn[0] <= cfg[pad_owner_pkg::OD_BIT] | padIn;
          pad_owner_pkg::OWN_HIPERF: ownIn[1] <= cfg[pad_owner_pkg::OD_BIT] | padIn;
          pad_owner_pkg::OWN_LOWPWR: ownIn[2] <= cfg[pad_owner_pkg::OD_BIT] | padIn;
          default:                   ownIn    <= 3'h0;
        endcase
      end
    end
  end

  // ********************************************
  // Checks
  // ********************************************
  offWhenForced_a: assert property (@(posedge ref_clk) disable iff (srst)
    forceOff |=> !padOe)
    else $error("pad enabled while forced off");
  odNeverHigh_a: assert property (@(posedge ref_clk) disable iff (srst)
    cfg[pad_owner_pkg::OD_BIT] && $stable(cfg) |=> !(padOe && padOut))
    else $error("open drain pad drove high");
  secureGated_a: assert property (@(posedge ref_clk) disable iff (srst)
    (owner != pad_owner_pkg::OWN_LOWPWR) && !hiPerfOk |=> !padOe)
    else $error("fast owner pad enabled outside active states");
  lowPwrGated_a: assert property (@(posedge ref_clk) disable iff (srst)
    (owner == pad_owner_pkg::OWN_LOWPWR) && !lowPwrOk |=> !padOe)
    else $error("low power pad enabled in sleep");

endmodule
